//--- rtl/udc_counter.v
// dual clock presettable up/down counter, decade or binary variant
//
// Overview of operation
// - decade variant counts ten BCD states, 8-4-2-1 weighted, four flip-flops
// - binary variant counts all sixteen states in both directions
// - up clock rising edge adds exactly one
// - down clock rising edge subtracts exactly one
// - all four bits change together from common up and down lines
// - carry rests high, low only at maximum while up clock low
// - borrow low only at zero while down clock low
// - carry and borrow are terminal decode ANDed with inverted clock
// - master clear high zeroes count, blocks preset, ignores clocks
// - load low with clear low copies preset value into count
// - clock low through clear or load counts on its next rise
`timescale 1ns/1ps
`include "udc_regs.vh"

module udc_counter #(
  parameter DECADE = 1'b1
) (
  // system
  input wire i_mclk,
  input wire i_rst,
  // count clocks from the outside
  input wire i_up_count_clock,
  input wire i_down_count_clock,
  // asynchronous overrides
  input wire i_master_clear,
  input wire i_parallel_load_n,
  input wire [`UDC_WIDTH-1:0] i_preset_value,
  // state and cascade outputs
  output reg [`UDC_WIDTH-1:0] o_count_value,
  output reg o_carry_out_n,
  output reg o_borrow_out_n
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers, two flops each
reg up_meta;
reg up_sync;
reg dn_meta;
reg dn_sync;
reg clr_meta;
reg clr_sync;
reg ld_meta;
reg ld_sync;
reg [`UDC_WIDTH-1:0] pre_meta;
reg [`UDC_WIDTH-1:0] pre_sync;

always @(posedge i_mclk or posedge i_rst) begin
  if (i_rst) begin
    up_meta <= 1'b1;
    up_sync <= 1'b1;
    dn_meta <= 1'b1;
    dn_sync <= 1'b1;
    clr_meta <= 1'b0;
    clr_sync <= 1'b0;
    ld_meta <= 1'b1;
    ld_sync <= 1'b1;
    pre_meta <= `UDC_ZERO;
    pre_sync <= `UDC_ZERO;
  end else begin
    up_meta <= i_up_count_clock;
    up_sync <= up_meta;
    dn_meta <= i_down_count_clock;
    dn_sync <= dn_meta;
    clr_meta <= i_master_clear;
    clr_sync <= clr_meta;
    ld_meta <= i_parallel_load_n;
    ld_sync <= ld_meta;
    pre_meta <= i_preset_value;
    pre_sync <= pre_meta;
  end
end

////////////////////////////////////////////////////////////////////////////////
// previous clock levels for rising edge detection
reg up_prev;
reg dn_prev;

// edge history keeps tracking during clear and load, so a low clock still counts later
always @(posedge i_mclk or posedge i_rst) begin
  if (i_rst) begin
    up_prev <= 1'b1;
    dn_prev <= 1'b1;
  end else begin
    up_prev <= up_sync;
    dn_prev <= dn_sync;
  end
end

wire up_rise = up_sync & ~up_prev;
wire dn_rise = dn_sync & ~dn_prev;
wire [`UDC_WIDTH-1:0] top_state = DECADE ? `UDC_DEC_MAX : `UDC_BIN_MAX;

////////////////////////////////////////////////////////////////////////////////
// next count value
reg [`UDC_WIDTH-1:0] count;
reg [`UDC_WIDTH-1:0] next_count;

always @* begin
  next_count = count;
  if (clr_sync) begin
    next_count = `UDC_ZERO;
  end else if (!ld_sync) begin
    next_count = pre_sync;
  end else if (up_rise && dn_sync) begin
    if (count >= top_state) begin
      next_count = `UDC_ZERO;
    end else begin
      next_count = count + `UDC_ONE;
    end
  end else if (dn_rise && up_sync) begin
    if (count == `UDC_ZERO) begin
      next_count = top_state;
    end else begin
      next_count = count - `UDC_ONE;
    end
  end
  // other clock low: no count, the driver must hold it high; both edges in one cycle count up
end

// all four bits on one edge
always @(posedge i_mclk or posedge i_rst) begin
  if (i_rst) begin
    count <= `UDC_ZERO;
  end else begin
    count <= next_count;
  end
end

////////////////////////////////////////////////////////////////////////////////
// registered outputs: state and terminal decodes gated by inverted clocks
always @(posedge i_mclk or posedge i_rst) begin
  if (i_rst) begin
    o_count_value <= `UDC_ZERO;
    o_carry_out_n <= 1'b1;
    o_borrow_out_n <= 1'b1;
  end else begin
    o_count_value <= next_count;
    o_carry_out_n <= ~((next_count == top_state) & ~up_sync);
    o_borrow_out_n <= ~((next_count == `UDC_ZERO) & ~dn_sync);
  end
end

endmodule // udc_counter

//--- rtl/udc_regs.vh
// constants for the dual clock up/down counter
`ifndef UDC_REGS_VH
`define UDC_REGS_VH
`define UDC_WIDTH 4
`define UDC_ZERO 4'h0
`define UDC_ONE 4'h1
`define UDC_DEC_MAX 4'h9
`define UDC_BIN_MAX 4'hF
`define UDC_SYNC_STAGES 2
`endif

//--- bench/udc_src.sv
// count clock source, idle high
`timescale 1ns/1ps
module udc_src (input wire [1:0] i_low, output wire o_up, output wire o_dn);
  // only the asked line goes low
  assign o_up = !i_low[0];
  assign o_dn = !i_low[1];
endmodule // udc_src

//--- bench/udc_checker.sv
// counter port assertions
`timescale 1ns/1ps
module udc_checker #(parameter DECADE = 1'b1) (input wire i_mclk, i_rst, i_up_count_clock,
  i_down_count_clock, i_master_clear, i_parallel_load_n, o_carry_out_n, o_borrow_out_n,
  input wire [3:0] i_preset_value, o_count_value);
  wire [3:0] q = o_count_value, t = DECADE ? 4'h9 : 4'hF;
  wire u = i_up_count_clock, d = i_down_count_clock, k = !i_master_clear && i_parallel_load_n;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence ev(a, b); $rose(a) && b && k ##1 (b && k) [*3]; endsequence
  clear_zero_a: assert property (i_master_clear [*4] |-> q == 4'h0) else $error("clr");
  load_copy_a: assert property ((!i_parallel_load_n && !i_master_clear
    && $stable(i_preset_value)) [*5] |-> q == i_preset_value) else $error("load");
  up_step_a: assert property (ev(u, d) |-> q == ($past(q) >= t ? 4'h0 : $past(q) + 4'h1))
    else $error("up");
  down_step_a: assert property (ev(d, u) |-> q == ($past(q) == 4'h0 ? t : $past(q) - 4'h1))
    else $error("down");
  hold_still_a: assert property ((u && d && k) [*6] |-> $stable(q)) else $error("hold");
  carry_cause_a: assert property (!o_carry_out_n |-> q == t && !$past(u, 3))
    else $error("carry");
  borrow_cause_a: assert property (!o_borrow_out_n |-> q == 4'h0 && !$past(d, 3))
    else $error("borrow");
  carry_repeat_a: assert property ((q == t && !u) [*4] |-> !o_carry_out_n)
    else $error("repeat");
endmodule // udc_checker
bind udc_counter udc_checker #(.DECADE(DECADE)) chk_u (.*);

//--- bench/tb.sv
// random bench for the counter
`timescale 1ns/1ps
module tb;
  reg i_mclk = 0, i_rst = 1, i_master_clear = 0, i_parallel_load_n = 1;
  reg [3:0] i_preset_value = 4'h0, e = 4'h0, p = 4'h0, a = 4'h0;
  reg [1:0] m = 2'h0;
  reg [31:0] r = 32'h4AB50B2E;
  wire i_up_count_clock, i_down_count_clock, o_carry_out_n, o_borrow_out_n;
  wire [3:0] o_count_value;
  integer bad_count = 0, n_tests = 0;
  always #10 i_mclk = ~i_mclk;
  udc_src src_u (.i_low(m), .o_up(i_up_count_clock), .o_dn(i_down_count_clock));
  udc_counter dut_u (.*);
  function [31:0] xs(input [31:0] a);
    xs = a ^ (a << 13) ^ ((a ^ (a << 13)) >> 17);
  endfunction
  // expected count: load, up, down or clear
  function [3:0] nx(input [3:0] v, input [1:0] o);
    nx = o == 2'h0 ? r[7:4] : &o ? 4'h0 : o[0] ? (v > 4'h8 ? 4'h0 : v + 4'h1)
      : (v == 4'h0 ? 4'h9 : v - 4'h1);
  endfunction
  task chk(input [3:0] s, x);
    begin
      n_tests = n_tests + 1;
      if (s !== x) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: %h not %h", $time, s, x);
      end
    end
  endtask
  task end_sim;
    begin
      $display("%0d checks, %0d wrong", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // one random operation every 15 cycles
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 0;
    repeat (300) begin
      r = xs(r) ^ (xs(r) << 5);
      p = e;
      e = nx(e, r[1:0]);
      // count expected while the operation is still held
      a = r[1:0] == 2'h0 ? r[7:4] : &r[1:0] ? 4'h0 : p;
      i_preset_value <= r[7:4];
      i_master_clear <= &r[1:0];
      i_parallel_load_n <= |r[1:0];
      // clear and load may keep one clock low through the override
      m <= r[1:0] == 2'h0 ? {1'b0, r[8]} : &r[1:0] ? {r[8], 1'b0} : r[1:0];
      repeat (6) @(posedge i_mclk);
      chk(o_count_value, a);
      chk({3'h0, o_carry_out_n}, {3'h0, !(m[0] && a == 4'h9)});
      chk({3'h0, o_borrow_out_n}, {3'h0, !(m[1] && a == 4'h0)});
      if (r[8] && !(^r[1:0]))
        e = nx(e, r[1:0] == 2'h0 ? 2'h1 : 2'h2);
      {m, i_master_clear, i_parallel_load_n} <= 4'h1;
      repeat (9) @(posedge i_mclk);
      chk(o_count_value, e);
    end
    end_sim;
  end
  initial begin
    #150000;
    bad_count = bad_count + 1;
    end_sim;
  end
endmodule // tb
